/* File: hw/gpp_defs.vh */
// Constants for the general purpose I/O port: APB offsets, pin
// configuration fields and their codes, reset values.
// Assumes inclusion by bare name from the design file.
`ifndef GPP_DEFS_VH
`define GPP_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define GPP_A_DIR     12'h000
`define GPP_A_DIRSET  12'h004
`define GPP_A_DIRCLR  12'h008
`define GPP_A_DIRTGL  12'h00C
`define GPP_A_OUT     12'h010
`define GPP_A_OUTSET  12'h014
`define GPP_A_OUTCLR  12'h018
`define GPP_A_OUTTGL  12'h01C
`define GPP_A_IN      12'h020
`define GPP_A_INTCTRL 12'h024
`define GPP_A_INT0MSK 12'h028
`define GPP_A_INT1MSK 12'h02C
`define GPP_A_INTFLG  12'h030
`define GPP_A_MPCMSK  12'h034
`define GPP_A_OUTSEL  12'h038
`define GPP_A_LAST    12'h038
// Pin configuration words occupy 0x040..0x05C, one per pin
`define GPP_CFG_PAGE  7'h02

// ****************************************
// Pin configuration fields and codes
// ****************************************
`define GPP_F_ISC     2:0
`define GPP_F_OPC     5:3
`define GPP_F_INV     6
`define GPP_ISC_BOTH  3'h0
`define GPP_ISC_RISE  3'h1
`define GPP_ISC_FALL  3'h2
`define GPP_ISC_LEVEL 3'h3
`define GPP_OPC_TOTEM 3'h0
`define GPP_OPC_KEEP  3'h1
`define GPP_OPC_PDN   3'h2
`define GPP_OPC_PUP   3'h3
`define GPP_OPC_WOR   3'h4
`define GPP_OPC_WAND  3'h5
`define GPP_OPC_WORPD 3'h6
`define GPP_OPC_WANDPU 3'h7

// ****************************************
// Other fields and reset values
// ****************************************
`define GPP_LVL_OFF   2'h0
`define GPP_SEL_CLK   0
`define GPP_SEL_EV7   1
`define GPP_RST_CFG   7'h00
`define GPP_RST_BYTE  8'h00

`endif

/* File: hw/gpp_port.v */
// Eight-pin general purpose I/O port with APB register access,
// per-pin sensing, two port interrupts and alternate function override.
// Assumes pins, alternate function signals and APB are synchronous to mclk.
// Assumes a pad cell outside resolves pinOut, pinOe_n and the pull enables.
// Assumes the routed clock and event inputs arrive as synchronous levels.
//
// Overview of operation
// - Port has up to eight pins 0..7, each configured on its own.
// - Every pin has its own direction bit.
// - Inverted input pins read back complemented.
// - Inverted output pins drive the complement of the output bit.
// - Inversion also applies to alternate function data.
// - Driver per pin: totem, pull-up/down, wired-AND/OR, bus-keeper.
// - Bus-keeper weakly holds the last level seen on the pin.
// - Per-pin sense of both edges, rising, falling or low level.
// - Sensing is clocked when port clock runs, asynchronous otherwise.
// - Inversion is applied before the sense logic.
// - Every sense mode can raise wake without the port clock.
// - Two interrupt outputs, each with own level.
// - Each interrupt has its own per-pin source mask.
// - Interrupt requested when a masked pin meets its sense condition.
// - Output and direction have set, clear and toggle locations.
// - One configuration write may reach several pins at once.
// - Peripheral clock or event channel 7 may drive a pin.
// - Enabled alternate function takes over the pin unless clock or event channel 7 is routed there.
// - Direction and output reachable by single-bit virtual port access.
// - Interrupt level selects high, medium or low.
`include "gpp_defs.vh"
`default_nettype none

module gpp_port #(
    parameter NPIN    = 8,
    parameter CLK_PIN = 7
) (
    // Clock, reset and APB slave
    input  wire              mclk,
    input  wire              reset,
    input  wire [11:0]       paddr,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output wire              pready,
    output wire              pslverr,
    // Pads
    input  wire [NPIN-1:0]   pinIn,
    output reg  [NPIN-1:0]   pinOut,
    output reg  [NPIN-1:0]   pinOe_n,
    output reg  [NPIN-1:0]   pullUpEn,
    output reg  [NPIN-1:0]   pullDnEn,
    // Alternate function override from peripherals
    input  wire [NPIN-1:0]   altEn,
    input  wire [NPIN-1:0]   altOut,
    input  wire [NPIN-1:0]   altOe,
    output reg  [NPIN-1:0]   altIn,
    // Routed sources and port clock state
    input  wire              clkOutSrc,
    input  wire              evCh7,
    input  wire              portClkEn,
    // Sense and interrupt outputs
    output wire              wakeReq,
    output reg  [NPIN-1:0]   senseEv,
    output reg               intReq0,
    output reg               intReq1,
    output wire [1:0]        intLvl0,
    output wire [1:0]        intLvl1,
    // Single-bit register access
    input  wire              vpWe,
    input  wire              vpSelOut,
    input  wire [2:0]        vpBit,
    input  wire              vpVal,
    output wire              vpRd
);

// ****************************************
// Registers
// ****************************************
// Register file; set, clear and toggle views have no storage of their own
reg  [NPIN-1:0] dir_q, dir_d;
reg  [NPIN-1:0] out_q, out_d;
reg  [3:0]      intCtl_q, intCtl_d;
reg  [NPIN-1:0] mask0_q, mask0_d;
reg  [NPIN-1:0] mask1_q, mask1_d;
reg  [1:0]      flags_q, flags_d;
reg  [NPIN-1:0] mpc_q, mpc_d;
reg  [1:0]      outSel_q, outSel_d;
// Sensed pin values, frozen while the port clock is stopped
reg  [NPIN-1:0] prev_q;
// Raw pin level of the last cycle, the keeper's memory
reg  [NPIN-1:0] keep_q;
// Per pin: sense mode, driver mode and inversion
reg  [6:0]      cfg_q [0:NPIN-1];
integer         k;

// ****************************************
// APB decode
// ****************************************
wire        setupPh = psel & ~penable;
wire        accPh   = psel & penable;
wire        wrEn    = accPh & pwrite;
// Pin configuration words sit in their own 32-byte page
// Misaligned or unmapped accesses get a slave error; a misaligned pin configuration write still lands
wire        isCfg   = (paddr[11:5] == `GPP_CFG_PAGE) && (paddr[4:2] < NPIN);
wire        mapped  = (paddr[1:0] == 2'h0) && ((paddr <= `GPP_A_LAST) || isCfg);
wire [NPIN-1:0] wd  = pwdata[NPIN-1:0];

// Read data is latched in the setup phase so the access phase needs no wait
assign pready  = 1'b1;
// Error only in the access phase, never while the request is set up
assign pslverr = accPh & ~mapped;

// ****************************************
// Sensing and pin values
// ****************************************
wire [NPIN-1:0] pinVal;
wire [NPIN-1:0] hit;
wire [NPIN-1:0] lowAct;
wire [NPIN-1:0] drv;
wire [NPIN-1:0] oe;
wire [NPIN-1:0] pu;
wire [NPIN-1:0] pd;

// Edge modes compare against the last sampled value; the low-level mode
// needs no history and so keeps requesting while the pin stays low.
genvar i;
generate
    for (i = 0; i < NPIN; i = i + 1) begin : gPin
        wire [2:0] isc = cfg_q[i][`GPP_F_ISC];
        wire [2:0] opc = cfg_q[i][`GPP_F_OPC];
        wire       inv = cfg_q[i][`GPP_F_INV];
        reg        h;
        reg        src;
        reg        en;
        reg        o;
        reg        u;
        reg        dn;
        assign pinVal[i] = pinIn[i] ^ inv;
        always @* begin
            case (isc)
                `GPP_ISC_BOTH:  h = pinVal[i] ^ prev_q[i];
                `GPP_ISC_RISE:  h = pinVal[i] & ~prev_q[i];
                `GPP_ISC_FALL:  h = ~pinVal[i] & prev_q[i];
                `GPP_ISC_LEVEL: h = ~pinVal[i];
                default:        h = 1'b0;
            endcase
        end
        assign hit[i]    = h;
        assign lowAct[i] = (isc == `GPP_ISC_LEVEL) & ~pinVal[i];

        always @* begin
            // Alternate function wins over port data; routed clock/event win over both
            src = altEn[i] ? altOut[i] : out_q[i];
            en  = altEn[i] ? altOe[i] : dir_q[i];
            if (i == CLK_PIN && outSel_q[`GPP_SEL_CLK]) begin
                src = clkOutSrc;
                en  = 1'b1;
            end else if (i == CLK_PIN && outSel_q[`GPP_SEL_EV7]) begin
                src = evCh7;
                en  = 1'b1;
            end
            o  = en;
            u  = 1'b0;
            dn = 1'b0;
            // Wired modes drive only their active level and float the other
            case (opc)
                `GPP_OPC_TOTEM: o = en;
                `GPP_OPC_KEEP: begin
                    // Pull toward the remembered level only while not driving
                    u  = ~en & keep_q[i];
                    dn = ~en & ~keep_q[i];
                end
                `GPP_OPC_PDN:   dn = ~en;
                `GPP_OPC_PUP:   u  = ~en;
                `GPP_OPC_WOR:   o  = en & (src ^ inv);
                `GPP_OPC_WAND:  o  = en & ~(src ^ inv);
                `GPP_OPC_WORPD: begin
                    o  = en & (src ^ inv);
                    dn = 1'b1;
                end
                `GPP_OPC_WANDPU: begin
                    o  = en & ~(src ^ inv);
                    u  = 1'b1;
                end
                default: o = en;
            endcase
        end
        // Inversion sits between port data and pad in every mode
        assign drv[i] = src ^ inv;
        assign oe[i]  = o;
        assign pu[i]  = u;
        assign pd[i]  = dn;
    end
endgenerate

// Clocked sensing only while the port clock runs; otherwise the sense
// condition against the frozen previous value is flagged combinationally.
// Limitation: the wake path is combinational and may glitch; the power
// controller is expected to filter it before use.
wire [NPIN-1:0] hitSync = hit & {NPIN{portClkEn}};
assign wakeReq = ~portClkEn & (|(hit & (mask0_q | mask1_q)));

// Masks select which pins feed each request
wire hit0 = |(hitSync & mask0_q);
wire hit1 = |(hitSync & mask1_q);
wire low0 = |(lowAct & mask0_q);
wire low1 = |(lowAct & mask1_q);

// Levels pass straight out to the interrupt controller
assign intLvl0 = intCtl_q[1:0];
assign intLvl1 = intCtl_q[3:2];
// Single-bit view of direction or output for bit instructions
assign vpRd    = vpSelOut ? out_q[vpBit] : dir_q[vpBit];

// ****************************************
// Interrupt requests
// ****************************************
// The enable follows the level being written, so a request never
// outlives a write that turns its level off.
wire        lvlOn0   = (intCtl_d[1:0] != `GPP_LVL_OFF);
wire        lvlOn1   = (intCtl_d[3:2] != `GPP_LVL_OFF);
// Sticky sense flags or a live low level raise a request
wire        reqNext0 = (flags_d[0] | low0) & lvlOn0;
wire        reqNext1 = (flags_d[1] | low1) & lvlOn1;

// ****************************************
// Register next state
// ****************************************
always @* begin
    // Defaults hold every register
    dir_d    = dir_q;
    out_d    = out_q;
    intCtl_d = intCtl_q;
    mask0_d  = mask0_q;
    mask1_d  = mask1_q;
    mpc_d    = mpc_q;
    outSel_d = outSel_q;
    flags_d  = flags_q;
    if (wrEn) begin
        // Set, clear and toggle touch only the bits written as one
        case (paddr)
            `GPP_A_DIR:     dir_d = wd;
            `GPP_A_DIRSET:  dir_d = dir_q | wd;
            `GPP_A_DIRCLR:  dir_d = dir_q & ~wd;
            `GPP_A_DIRTGL:  dir_d = dir_q ^ wd;
            `GPP_A_OUT:     out_d = wd;
            `GPP_A_OUTSET:  out_d = out_q | wd;
            `GPP_A_OUTCLR:  out_d = out_q & ~wd;
            `GPP_A_OUTTGL:  out_d = out_q ^ wd;
            `GPP_A_INTCTRL: intCtl_d = pwdata[3:0];
            `GPP_A_INT0MSK: mask0_d = wd;
            `GPP_A_INT1MSK: mask1_d = wd;
            `GPP_A_INTFLG:  flags_d = flags_q & ~pwdata[1:0];
            `GPP_A_MPCMSK:  mpc_d = wd;
            `GPP_A_OUTSEL:  outSel_d = pwdata[1:0];
            default:        dir_d = dir_q;
        endcase
        // Multi-pin mask is one-shot: consumed by the next pin config write
        if (isCfg) begin
            mpc_d = {NPIN{1'b0}};
        end
    end
    // Single-bit access lands last so it wins over an APB write of that bit
    if (vpWe && !vpSelOut) begin
        dir_d[vpBit] = vpVal;
    end
    if (vpWe && vpSelOut) begin
        out_d[vpBit] = vpVal;
    end
    // A sense hit in the same cycle as a clear keeps its flag
    flags_d = flags_d | {hit1, hit0};
end

// ****************************************
// Clocked state
// ****************************************
always @(posedge mclk) begin
    if (reset) begin
        dir_q    <= {NPIN{1'b0}};
        out_q    <= {NPIN{1'b0}};
        intCtl_q <= 4'h0;
        mask0_q  <= {NPIN{1'b0}};
        mask1_q  <= {NPIN{1'b0}};
        flags_q  <= 2'h0;
        mpc_q    <= {NPIN{1'b0}};
        outSel_q <= 2'h0;
        prev_q   <= {NPIN{1'b0}};
        keep_q   <= {NPIN{1'b0}};
        for (k = 0; k < NPIN; k = k + 1) begin
            cfg_q[k] <= `GPP_RST_CFG;
        end
    end else begin
        dir_q    <= dir_d;
        out_q    <= out_d;
        intCtl_q <= intCtl_d;
        mask0_q  <= mask0_d;
        mask1_q  <= mask1_d;
        flags_q  <= flags_d;
        mpc_q    <= mpc_d;
        outSel_q <= outSel_d;
        // Keeper remembers the raw level, driven or held weakly
        keep_q   <= pinIn;
        // History only advances with the port clock, so a stopped clock
        // leaves the last seen levels for the wake comparison
        if (portClkEn) begin
            prev_q <= pinVal;
        end
        // With a multi-pin mask set, one write reaches every masked pin
        for (k = 0; k < NPIN; k = k + 1) begin
            if (wrEn && isCfg) begin
                if ((mpc_q != {NPIN{1'b0}}) ? mpc_q[k] : (paddr[4:2] == k)) begin
                    cfg_q[k] <= pwdata[6:0];
                end
            end
        end
    end
end

// ****************************************
// Registered outputs
// ****************************************
always @(posedge mclk) begin
    if (reset) begin
        // Pads released and pulls off while in reset
        prdata   <= 32'h00000000;
        pinOut   <= {NPIN{1'b0}};
        pinOe_n  <= {NPIN{1'b1}};
        pullUpEn <= {NPIN{1'b0}};
        pullDnEn <= {NPIN{1'b0}};
        altIn    <= {NPIN{1'b0}};
        senseEv  <= {NPIN{1'b0}};
        intReq0  <= 1'b0;
        intReq1  <= 1'b0;
    end else begin
        // Pin controls are registered so the pads never see decode glitches
        pinOut   <= drv;
        pinOe_n  <= ~oe;
        pullUpEn <= pu;
        pullDnEn <= pd;
        altIn    <= pinVal;
        senseEv  <= hitSync;
        intReq0  <= reqNext0;
        intReq1  <= reqNext1;
        // Read data is taken in the setup cycle, so pready can stay high;
        // pin values read back are one cycle older than the access edge
        if (setupPh) begin
            // Unused upper bits read as zero
            prdata <= 32'h00000000;
            if (isCfg) begin
                prdata[6:0] <= cfg_q[paddr[4:2]];
            end else begin
                case (paddr)
                    `GPP_A_DIR, `GPP_A_DIRSET, `GPP_A_DIRCLR, `GPP_A_DIRTGL:
                        prdata[NPIN-1:0] <= dir_q;
                    `GPP_A_OUT, `GPP_A_OUTSET, `GPP_A_OUTCLR, `GPP_A_OUTTGL:
                        prdata[NPIN-1:0] <= out_q;
                    `GPP_A_IN:      prdata[NPIN-1:0] <= pinVal;
                    `GPP_A_INTCTRL: prdata[3:0] <= intCtl_q;
                    `GPP_A_INT0MSK: prdata[NPIN-1:0] <= mask0_q;
                    `GPP_A_INT1MSK: prdata[NPIN-1:0] <= mask1_q;
                    `GPP_A_INTFLG:  prdata[1:0] <= flags_q;
                    `GPP_A_MPCMSK:  prdata[NPIN-1:0] <= mpc_q;
                    `GPP_A_OUTSEL:  prdata[1:0] <= outSel_q;
                    default:        prdata <= 32'h00000000;
                endcase
            end
        end
    end
end

endmodule

`default_nettype wire

/* File: testbench/gpp_pin_model.sv */
// Wire-level model of circuitry on the eight port pins.
// Assumes the port and the bench drivers share mclk.
`default_nettype none
module gpp_pin_model (
    input wire logic       mclk,
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe_n,
    input wire logic [7:0] pullUpEn,
    input wire logic [7:0] pullDnEn,
    input wire logic [7:0] extEn,
    input wire logic [7:0] extVal,
    output logic [7:0]     pinLvl
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // Pin resolution
    // ****************
    logic [7:0] lastQ;
    // A floating pin flips each cycle so no settled value is ever read by luck
    always_comb
        for (int i = 0; i < 8; i++)
            if (!pinOe_n[i]) pinLvl[i] = pinOut[i];
            else if (extEn[i]) pinLvl[i] = extVal[i];
            else if (pullUpEn[i]) pinLvl[i] = 1'b1;
            else if (pullDnEn[i]) pinLvl[i] = 1'b0;
            else pinLvl[i] = ~lastQ[i];
    always @(posedge mclk) lastQ <= pinLvl;
endmodule
`default_nettype wire

/* File: testbench/gpp_port_bench.sv */
// Self-checking bench for the I/O port over APB and its pins.
// Assumes gpp_port with eight pins and the pin model beside it.
`default_nettype none
module gpp_port_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, reset, psel, penable, pwrite, pready, pslverr, slv;
    logic        clkOutSrc, evCh7, portClkEn, wakeReq, intReq0, intReq1;
    logic        vpWe, vpSelOut, vpVal, vpRd;
    logic [1:0]  intLvl0, intLvl1;
    logic [2:0]  vpBit;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [7:0]  pinLvl, pinOut, pinOe_n, pullUpEn, pullDnEn, altIn, senseEv;
    logic [7:0]  altEn, altOut, altOe, extEn, extVal;
    int          errors, nTests;
    gpp_port dut_u (.mclk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .pinIn(pinLvl), .pinOut, .pinOe_n, .pullUpEn, .pullDnEn, .altEn,
        .altOut, .altOe, .altIn, .clkOutSrc, .evCh7, .portClkEn, .wakeReq, .senseEv,
        .intReq0, .intReq1, .intLvl0, .intLvl1, .vpWe, .vpSelOut, .vpBit, .vpVal, .vpRd);
    gpp_pin_model pin_u (.mclk, .pinOut, .pinOe_n, .pullUpEn, .pullDnEn, .extEn, .extVal,
        .pinLvl);
    // ****************
    // Shared tasks
    // ****************
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rdat = prdata;
        slv = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic pin0(input logic v);
        extVal[0] <= v;
        tick(4);
    endtask
    task automatic pulse(input logic v, input logic [7:0] exp);
        extVal[0] <= v;
        @(posedge mclk);
        @(negedge mclk);
        chk("senseEv", senseEv, exp);
        @(posedge mclk);
        @(negedge mclk);
        chk("senseOne", senseEv, 8'h00);
        tick(2);
    endtask
    task automatic clr;
        wr(12'h030, 32'h3);
        tick(2);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", nTests, errors);
        if (errors == 0 && nTests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_regs;
        logic [11:0] a [8] = '{12'h000, 12'h004, 12'h008, 12'h00C,
                               12'h010, 12'h014, 12'h018, 12'h01C};
        logic [7:0]  d [8] = '{8'h3C, 8'h40, 8'h30, 8'h08, 8'h10, 8'h05, 8'h11, 8'h01};
        for (int i = 0; i < 8; i++) wr(a[i], {24'h0, d[i]});
        tick(2);
        rd(12'h000);
        chk("dir", rdat, 32'h44);
        rd(12'h010);
        chk("out", rdat, 32'h05);
        chk("oe", pinOe_n, 8'hBB);
        chk("drive", {pinOut[6], pinOut[2]}, 2'b01);
        rd(12'h03C);
        chk("unmapped", {31'h0, slv}, 32'h1);
        chk("unmappedRd", rdat, 32'h0);
        wr(12'h048, 32'h40);
        tick(2);
        chk("invOut", pinOut[2], 1'b0);
        rd(12'h020);
        chk("invIn", rdat[2], 1'b1);
        $display("t_regs done");
    endtask
    task automatic t_sense;
        wr(12'h024, 32'h0D);
        wr(12'h028, 32'h01);
        wr(12'h02C, 32'h02);
        chk("lvl", {intLvl1, intLvl0}, 4'hD);
        for (int m = 0; m < 4; m++) begin
            wr(12'h040, 32'(m));
            pin0(1'b0);
            clr;
            chk("lowHold", intReq0, m == 3);
            pulse(1'b1, {7'h0, m < 2});
            chk("rise", intReq0, m != 2);
            clr;
            chk("clear", intReq0, 1'b0);
            pin0(1'b0);
            chk("fall", intReq0, m != 1);
            chk("mask1", intReq1, 1'b0);
            pin0(1'b1);
            clr;
        end
        portClkEn <= 1'b0;
        pin0(1'b0);
        chk("wake", wakeReq, 1'b1);
        chk("lowAsync", intReq0, 1'b1);
        rd(12'h030);
        chk("noFlag", rdat, 32'h0);
        portClkEn <= 1'b1;
        pin0(1'b1);
        $display("t_sense done");
    endtask
    task automatic t_pins;
        wr(12'h034, 32'h03);
        wr(12'h040, 32'h41);
        extVal[1] <= 1'b0;
        tick(3);
        rd(12'h020);
        chk("multiIn", rdat[1:0], 2'b10);
        wr(12'h050, 32'h08);
        extVal[4] <= 1'b1;
        tick(3);
        extEn[4] <= 1'b0;
        tick(4);
        chk("keepHi", {pullUpEn[4], pullDnEn[4]}, 2'b10);
        {extEn[4], extVal[4]} <= 2'b10;
        tick(3);
        extEn[4] <= 1'b0;
        tick(4);
        chk("keepLo", {pullUpEn[4], pullDnEn[4]}, 2'b01);
        wr(12'h050, 32'h18);
        tick(2);
        chk("pullUp", {pullUpEn[4], pullDnEn[4]}, 2'b10);
        {vpSelOut, vpBit, vpVal, vpWe} <= 6'b1_101_1_1;
        tick(1);
        vpWe <= 1'b0;
        tick(2);
        chk("vpRd", vpRd, 1'b1);
        rd(12'h010);
        chk("vpOut", rdat, 32'h25);
        {altEn, altOe, altOut} <= {3{8'h08}};
        wr(12'h04C, 32'h40);
        tick(3);
        chk("alt", {pinOe_n[3], pinOut[3], altIn[3]}, 3'b001);
        evCh7 <= 1'b1;
        wr(12'h038, 32'h03);
        tick(2);
        chk("clkPin", {pinOe_n[7], pinOut[7]}, 2'b00);
        wr(12'h038, 32'h02);
        tick(2);
        chk("evPin", pinOut[7], 1'b1);
        $display("t_pins done");
    endtask
    // ****************
    // Run control
    // ****************
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        errors++;
        end_sim;
    end
    initial begin
        {reset, portClkEn, extEn, extVal} = {2'b11, 8'hFF, 8'h00};
        {psel, penable, pwrite, paddr, pwdata, altEn, altOut, altOe} = '0;
        {clkOutSrc, evCh7, vpWe, vpSelOut, vpBit, vpVal} = '0;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        t_regs;
        t_sense;
        t_pins;
        end_sim;
    end
endmodule
`default_nettype wire

/* File: testbench/gpp_port_sva.sv */
// Assertions on the I/O port top: APB answer, sensing and interrupts.
// Assumes binding into gpp_port with its default eight pins.
`default_nettype none
module gpp_port_sva (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic [7:0]  pinOe_n,
    input wire logic        portClkEn,
    input wire logic        wakeReq,
    input wire logic [7:0]  senseEv,
    input wire logic        intReq0,
    input wire logic [1:0]  intLvl0,
    input wire logic        vpWe,
    input wire logic        vpSelOut,
    input wire logic [2:0]  vpBit,
    input wire logic        vpVal,
    input wire logic        vpRd
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // Properties
    // ****************
    default clocking @(posedge mclk); endclocking
    slverr_a: assert property (disable iff (reset) pslverr |-> psel && penable)
        else $error("slave error outside access phase");
    rd_hold_a: assert property (disable iff (reset) !(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside setup");
    wake_a: assert property (disable iff (reset) wakeReq |-> !portClkEn)
        else $error("wake request while port clock runs");
    sense_clk_a: assert property (disable iff (reset) senseEv != 8'h00 |-> $past(portClkEn))
        else $error("sense event without port clock");
    int_level_a: assert property (disable iff (reset) intReq0 |-> intLvl0 != 2'h0)
        else $error("request with level off");
    int_sticky_a: assert property (disable iff (reset)
        intReq0 && portClkEn && $past(portClkEn) && !(psel && pwrite) |=> intReq0)
        else $error("request dropped without a write");
    reset_state_a: assert property (reset |=> pinOe_n == 8'hFF && !intReq0 && prdata == 32'h0)
        else $error("outputs not at reset state");
    vp_write_a: assert property (disable iff (reset)
        vpWe ##1 ($stable(vpBit) && $stable(vpSelOut)) |-> vpRd == $past(vpVal))
        else $error("single-bit write not seen");
    cover property ($rose(intReq0));
    cover property (wakeReq);
    cover property (pslverr);
endmodule

bind gpp_port gpp_port_sva sva_u (.mclk, .reset, .psel, .penable, .pwrite, .prdata, .pslverr,
    .pinOe_n, .portClkEn, .wakeReq, .senseEv, .intReq0, .intLvl0, .vpWe, .vpSelOut, .vpBit,
    .vpVal, .vpRd);
`default_nettype wire
